/* File: shared/cssb_pkg.sv */
// Purpose: Shared constants and types for the status, stack and branch datapath
// Assumes: 8-bit data, 12-bit program counter, eight-level return stack
// Notes:   Field positions of the status word and the ALU/branch encodings
package cssb_pkg;

  localparam int          DATA_W        = 8;
  localparam int          PC_W          = 12;
  localparam int          SP_W          = 3;
  localparam int          RAM_AW        = 8;
  // Status word fields
  localparam int          SW_SP_LSB     = 0;
  localparam int          SW_BANK_BIT   = 4;
  localparam int          SW_FLAG_A_BIT = 5;
  localparam int          SW_AUX_BIT    = 6;
  localparam int          SW_CY_BIT     = 7;
  localparam logic [7:0]  SW_RESET      = 8'h08;
  localparam logic [7:0]  SW_USED_MASK  = 8'hf7;
  // First stack location in internal RAM
  localparam logic [7:0]  STACK_BASE    = 8'h08;
  localparam logic [7:0]  STACK_TOP     = 8'h17;

  typedef enum logic [3:0] {
    CSSB_ALU_ADD  = 4'h0,
    CSSB_ALU_ADDC = 4'h1,
    CSSB_ALU_AND  = 4'h2,
    CSSB_ALU_OR   = 4'h3,
    CSSB_ALU_XOR  = 4'h4,
    CSSB_ALU_DA   = 4'h5,
    CSSB_ALU_INC  = 4'h6,
    CSSB_ALU_DEC  = 4'h7,
    CSSB_ALU_CPL  = 4'h8,
    CSSB_ALU_CLR  = 4'h9,
    CSSB_ALU_RL   = 4'ha,
    CSSB_ALU_RLC  = 4'hb,
    CSSB_ALU_RR   = 4'hc,
    CSSB_ALU_RRC  = 4'hd,
    CSSB_ALU_SWAP = 4'he,
    CSSB_ALU_PASS = 4'hf
  } cssb_alu_type;

  typedef enum logic [3:0] {
    CSSB_BR_IRQ_LOW   = 4'h0,
    CSSB_BR_FLAG_A    = 4'h1,
    CSSB_BR_FLAG_B    = 4'h2,
    CSSB_BR_TIMER     = 4'h3,
    CSSB_BR_CARRY     = 4'h4,
    CSSB_BR_NO_CARRY  = 4'h5,
    CSSB_BR_ACC_ZERO  = 4'h6,
    CSSB_BR_ACC_NZ    = 4'h7,
    CSSB_BR_ACC_BIT   = 4'h8,
    CSSB_BR_TA_HIGH   = 4'h9,
    CSSB_BR_TA_LOW    = 4'ha,
    CSSB_BR_TB_HIGH   = 4'hb,
    CSSB_BR_TB_LOW    = 4'hc,
    CSSB_BR_DEC_NZ    = 4'hd,
    CSSB_BR_NONE      = 4'hf
  } cssb_branch_type;

  // Operation kind, one-hot
  typedef enum logic [5:0] {
    CSSB_OP_IDLE   = 6'b000001,
    CSSB_OP_ALU    = 6'b000010,
    CSSB_OP_BRANCH = 6'b000100,
    CSSB_OP_CALL   = 6'b001000,
    CSSB_OP_RET    = 6'b010000,
    CSSB_OP_SWMOVE = 6'b100000
  } cssb_op_type;

  // Decoded instruction word
  typedef struct packed {
    cssb_op_type     op;
    cssb_alu_type    alu_fn;
    cssb_branch_type br_cond;
    logic [2:0]      bit_sel;
    logic            dst_reg;
    logic            ret_restore;
    logic            sw_to_acc;
    logic [2:0]      reg_sel;
  } cssb_instr_type;

endpackage

/* File: rtl/cssb_core.sv */
// Purpose: Accumulator ALU, flags, status word, branch test and return stack
// Assumes: One instruction presented per cycle while instr_valid is high
// Notes:   Stack lives in internal RAM; this block drives the RAM write port
`default_nettype none

module cssb_core
  import cssb_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                instr_valid,
  input  wire cssb_instr_type      instr,
  input  wire logic [DATA_W-1:0]   bus_data,
  input  wire logic [PC_W-1:0]     branch_target,
  input  wire logic [PC_W-1:0]     pc_in,
  input  wire logic                irq_b,
  input  wire logic                user_flag_b,
  input  wire logic                timer_flag,
  input  wire logic                test_a,
  input  wire logic                test_b,
  input  wire logic [DATA_W-1:0]   ram_rd_lo,
  input  wire logic [DATA_W-1:0]   ram_rd_hi,
  output logic [DATA_W-1:0]        acc,
  output logic [DATA_W-1:0]        status_word,
  output logic [DATA_W-1:0]        reg_wr_data,
  output logic                     reg_wr_en,
  output logic [2:0]               reg_wr_sel,
  output logic                     pc_load,
  output logic [PC_W-1:0]          pc_load_value,
  output logic                     ram_wr_en,
  output logic [RAM_AW-1:0]        ram_addr,
  output logic [DATA_W-1:0]        ram_wr_lo,
  output logic [DATA_W-1:0]        ram_wr_hi
);

  // Slot address for a pointer value
  function automatic logic [RAM_AW-1:0] slot_addr(input logic [SP_W-1:0] sp);
    slot_addr = STACK_BASE + {4'h0, sp, 1'b0};
  endfunction

  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic ci);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction

  logic [DATA_W-1:0] acc_reg, acc_next;
  logic [DATA_W-1:0] sw_reg, sw_next;
  logic [DATA_W-1:0] reg_wr_data_reg;
  logic              reg_wr_en_reg;
  logic [2:0]        reg_wr_sel_reg;
  logic              pc_load_reg;
  logic [PC_W-1:0]   pc_load_value_reg;
  logic              ram_wr_en_reg;
  logic [RAM_AW-1:0] ram_addr_reg;
  logic [DATA_W-1:0] ram_wr_lo_reg, ram_wr_hi_reg;

  wire logic [SP_W-1:0] sp_cur  = sw_reg[SW_SP_LSB +: SP_W];
  wire logic [SP_W-1:0] sp_up   = sp_cur + 3'h1;
  wire logic [SP_W-1:0] sp_down = sp_cur - 3'h1;
  wire logic            cy      = sw_reg[SW_CY_BIT];
  wire logic            aux     = sw_reg[SW_AUX_BIT];

  wire logic is_alu  = instr_valid && (instr.op == CSSB_OP_ALU);
  wire logic is_br   = instr_valid && (instr.op == CSSB_OP_BRANCH);
  wire logic is_call = instr_valid && (instr.op == CSSB_OP_CALL);
  wire logic is_ret  = instr_valid && (instr.op == CSSB_OP_RET);
  wire logic is_swmv = instr_valid && (instr.op == CSSB_OP_SWMOVE);

  // Source operand: register decrement uses the bus byte as the register value
  wire logic [8:0] sum_add  = add9(acc_reg, bus_data, 1'b0);
  wire logic [8:0] sum_addc = add9(acc_reg, bus_data, cy);
  wire logic [4:0] nib_add  = {1'b0, acc_reg[3:0]} + {1'b0, bus_data[3:0]};
  wire logic [4:0] nib_addc = {1'b0, acc_reg[3:0]} + {1'b0, bus_data[3:0]} + {4'h0, cy};

  // Decimal adjust: low then high correction, carry sticks once set
  wire logic       da_lo_fix = aux || (acc_reg[3:0] > 4'h9);
  wire logic [8:0] da_step1  = add9(acc_reg, da_lo_fix ? 8'h06 : 8'h00, 1'b0);
  wire logic       da_hi_fix = cy || da_step1[8] || (da_step1[7:4] > 4'h9);
  wire logic [8:0] da_step2  = add9(da_step1[7:0], da_hi_fix ? 8'h60 : 8'h00, 1'b0);

  wire logic [DATA_W-1:0] dec_val = bus_data - 8'h01;

  logic [DATA_W-1:0] alu_res;
  logic              alu_cy, alu_aux, alu_flags;

  always_comb begin
    alu_res   = acc_reg;
    alu_cy    = cy;
    alu_aux   = aux;
    alu_flags = 1'b0;
    case (instr.alu_fn)
      CSSB_ALU_ADD: begin
        alu_res = sum_add[7:0];
        alu_cy = sum_add[8];
        alu_aux = nib_add[4];
        alu_flags = 1'b1;
      end
      CSSB_ALU_ADDC: begin
        alu_res = sum_addc[7:0];
        alu_cy = sum_addc[8];
        alu_aux = nib_addc[4];
        alu_flags = 1'b1;
      end
      CSSB_ALU_AND:  alu_res = acc_reg & bus_data;
      CSSB_ALU_OR:   alu_res = acc_reg | bus_data;
      CSSB_ALU_XOR:  alu_res = acc_reg ^ bus_data;
      CSSB_ALU_DA: begin
        alu_res = da_step2[7:0];
        alu_cy = da_hi_fix;
        alu_aux = aux;
        alu_flags = 1'b1;
      end
      CSSB_ALU_INC:  alu_res = bus_data + 8'h01;
      CSSB_ALU_DEC:  alu_res = dec_val;
      CSSB_ALU_CPL:  alu_res = ~acc_reg;
      CSSB_ALU_CLR:  alu_res = 8'h00;
      CSSB_ALU_RL:   alu_res = {acc_reg[6:0], acc_reg[7]};
      CSSB_ALU_RLC: begin
        alu_res = {acc_reg[6:0], cy};
        alu_cy = acc_reg[7];
        alu_flags = 1'b1;
      end
      CSSB_ALU_RR:   alu_res = {acc_reg[0], acc_reg[7:1]};
      CSSB_ALU_RRC: begin
        alu_res = {cy, acc_reg[7:1]};
        alu_cy = acc_reg[0];
        alu_flags = 1'b1;
      end
      CSSB_ALU_SWAP: alu_res = {acc_reg[3:0], acc_reg[7:4]};
      default:       alu_res = bus_data;
    endcase
  end

  // Branch condition; aux carry is deliberately absent from this selector
  logic br_true;
  always_comb begin
    case (instr.br_cond)
      CSSB_BR_IRQ_LOW:  br_true = !irq_b;
      CSSB_BR_FLAG_A:   br_true = sw_reg[SW_FLAG_A_BIT];
      CSSB_BR_FLAG_B:   br_true = user_flag_b;
      CSSB_BR_TIMER:    br_true = timer_flag;
      CSSB_BR_CARRY:    br_true = cy;
      CSSB_BR_NO_CARRY: br_true = !cy;
      CSSB_BR_ACC_ZERO: br_true = (acc_reg == 8'h00);
      CSSB_BR_ACC_NZ:   br_true = (acc_reg != 8'h00);
      CSSB_BR_ACC_BIT:  br_true = acc_reg[instr.bit_sel];
      CSSB_BR_TA_HIGH:  br_true = test_a;
      CSSB_BR_TA_LOW:   br_true = !test_a;
      CSSB_BR_TB_HIGH:  br_true = test_b;
      CSSB_BR_TB_LOW:   br_true = !test_b;
      CSSB_BR_DEC_NZ:   br_true = (dec_val != 8'h00);
      default:          br_true = 1'b0;
    endcase
  end

  wire logic br_is_dec = is_br && (instr.br_cond == CSSB_BR_DEC_NZ);
  wire logic alu_to_reg = is_alu && instr.dst_reg;
  wire logic alu_to_acc = is_alu && !instr.dst_reg;

  // Next accumulator and status word
  always_comb begin
    acc_next = acc_reg;
    sw_next  = sw_reg;
    if (alu_to_acc) begin
      acc_next = alu_res;
    end
    if (is_alu && alu_flags) begin
      sw_next[SW_CY_BIT]  = alu_cy;
      sw_next[SW_AUX_BIT] = alu_aux;
    end
    if (is_swmv && instr.sw_to_acc) begin
      acc_next = sw_reg;
    end else if (is_swmv) begin
      sw_next = acc_reg & SW_USED_MASK | SW_RESET & ~SW_USED_MASK;
    end
    if (is_call) begin
      sw_next[SW_SP_LSB +: SP_W] = sp_up;
    end
    if (is_ret) begin
      sw_next[SW_SP_LSB +: SP_W] = sp_down;
      if (instr.ret_restore) begin
        sw_next[7:4] = ram_rd_hi[7:4];
      end
    end
  end

  // Pointer used for the RAM access: push writes the current slot, pop reads the one below
  wire logic [RAM_AW-1:0] addr_next = is_ret ? slot_addr(sp_down) : slot_addr(sp_cur);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg           <= 8'h00;
      sw_reg            <= SW_RESET;
      reg_wr_data_reg   <= 8'h00;
      reg_wr_en_reg     <= 1'b0;
      reg_wr_sel_reg    <= 3'h0;
      pc_load_reg       <= 1'b0;
      pc_load_value_reg <= 12'h000;
      ram_wr_en_reg     <= 1'b0;
      ram_addr_reg      <= STACK_BASE;
      ram_wr_lo_reg     <= 8'h00;
      ram_wr_hi_reg     <= 8'h00;
    end else begin
      acc_reg           <= acc_next;
      sw_reg            <= sw_next;
      reg_wr_en_reg     <= alu_to_reg || br_is_dec;
      reg_wr_data_reg   <= br_is_dec ? dec_val : alu_res;
      reg_wr_sel_reg    <= instr.reg_sel;
      pc_load_reg       <= (is_br && br_true) || is_ret || is_call;
      pc_load_value_reg <= is_ret ? {ram_rd_hi[3:0], ram_rd_lo} : branch_target;
      ram_wr_en_reg     <= is_call;
      ram_addr_reg      <= addr_next;
      ram_wr_lo_reg     <= pc_in[7:0];
      ram_wr_hi_reg     <= {sw_reg[7:4], pc_in[11:8]};
    end
  end

  assign acc           = acc_reg;
  assign status_word   = sw_reg;
  assign reg_wr_data   = reg_wr_data_reg;
  assign reg_wr_en     = reg_wr_en_reg;
  assign reg_wr_sel    = reg_wr_sel_reg;
  assign pc_load       = pc_load_reg;
  assign pc_load_value = pc_load_value_reg;
  assign ram_wr_en     = ram_wr_en_reg;
  assign ram_addr      = ram_addr_reg;
  assign ram_wr_lo     = ram_wr_lo_reg;
  assign ram_wr_hi     = ram_wr_hi_reg;

  // Checks
  sequence s_call;
    is_call;
  endsequence

  property p_push_inc;
    @(posedge clk) disable iff (!rst_b)
      s_call |=> (status_word[2:0] == $past(sp_cur) + 3'h1) && ram_wr_en;
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push did not bump pointer");

  property p_push_addr;
    @(posedge clk) disable iff (!rst_b)
      s_call |=> ram_addr == STACK_BASE + {4'h0, $past(sp_cur), 1'b0};
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push slot address wrong");

  property p_push_data;
    @(posedge clk) disable iff (!rst_b)
      s_call |=> ram_wr_hi == {$past(sw_reg[7:4]), $past(pc_in[11:8])}
                 && ram_wr_lo == $past(pc_in[7:0]);
  endproperty
  a_push_data: assert property (p_push_data) else $error("pushed data layout wrong");

  property p_wrap_up;
    @(posedge clk) disable iff (!rst_b)
      (is_call && sp_cur == 3'h7) |=> status_word[2:0] == 3'h0;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("pointer did not wrap up");

  property p_ret_dec;
    @(posedge clk) disable iff (!rst_b)
      is_ret |=> status_word[2:0] == $past(sp_cur) - 3'h1 && pc_load;
  endproperty
  a_ret_dec: assert property (p_ret_dec) else $error("return did not drop pointer");

  property p_carry_add;
    @(posedge clk) disable iff (!rst_b)
      (is_alu && instr.alu_fn == CSSB_ALU_ADD) |=> status_word[7] == $past(sum_add[8]);
  endproperty
  a_carry_add: assert property (p_carry_add) else $error("add carry wrong");

  property p_aux_add;
    @(posedge clk) disable iff (!rst_b)
      (is_alu && instr.alu_fn == CSSB_ALU_ADD) |=> status_word[6] == $past(nib_add[4]);
  endproperty
  a_aux_add: assert property (p_aux_add) else $error("aux carry wrong");

  property p_branch_load;
    @(posedge clk) disable iff (!rst_b)
      is_br |=> pc_load == $past(br_true) && (!pc_load || pc_load_value == $past(branch_target));
  endproperty
  a_branch_load: assert property (p_branch_load) else $error("branch load wrong");

  property p_sw_write;
    @(posedge clk) disable iff (!rst_b)
      (is_swmv && !instr.sw_to_acc) |=> status_word == (($past(acc_reg) & 8'hf7) | 8'h08);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("status write wrong");

  property p_sw_read;
    @(posedge clk) disable iff (!rst_b)
      (is_swmv && instr.sw_to_acc) |=> acc == $past(sw_reg);
  endproperty
  a_sw_read: assert property (p_sw_read) else $error("status read wrong");

  // Decrement-and-branch writes the register back whether or not it jumps
  property p_dec_branch;
    @(posedge clk) disable iff (!rst_b)
      br_is_dec |=> reg_wr_en && reg_wr_data == $past(dec_val)
                    && pc_load == ($past(dec_val) != 8'h00);
  endproperty
  a_dec_branch: assert property (p_dec_branch) else $error("decrement branch wrong");

  property p_ret_load;
    @(posedge clk) disable iff (!rst_b)
      is_ret |=> pc_load_value == {$past(ram_rd_hi[3:0]), $past(ram_rd_lo)};
  endproperty
  a_ret_load: assert property (p_ret_load) else $error("return address wrong");

  property p_logic_flags;
    @(posedge clk) disable iff (!rst_b)
      (is_alu && (instr.alu_fn inside {CSSB_ALU_AND, CSSB_ALU_OR, CSSB_ALU_XOR}))
        |=> status_word[7:6] == $past(sw_reg[7:6]);
  endproperty
  a_logic_flags: assert property (p_logic_flags) else $error("logic op moved flags");

  // Slots never reach past the top of the stack area
  property p_slot_range;
    @(posedge clk) disable iff (!rst_b)
      ram_wr_en |-> ram_addr >= STACK_BASE && ram_addr < STACK_TOP;
  endproperty
  a_slot_range: assert property (p_slot_range) else $error("slot out of range");

  property p_idle_quiet;
    @(posedge clk) disable iff (!rst_b)
      !instr_valid |=> !pc_load && !reg_wr_en && !ram_wr_en;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("pulse without instruction");

endmodule

`default_nettype wire

/* File: test/tb.sv */
// Purpose: Self-checking bench for the status, stack and branch datapath
// Assumes: Results appear one cycle after an instruction is taken
// Notes:   Integer reference model; stack reads are fed from the model slots
`default_nettype none

module tb import cssb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst_b, instr_valid, irq_b, user_flag_b, timer_flag, test_a, test_b;
  cssb_instr_type instr;
  logic [7:0] bus_data, ram_rd_lo, ram_rd_hi, acc, status_word, reg_wr_data;
  logic [7:0] ram_addr, ram_wr_lo, ram_wr_hi;
  logic [11:0] branch_target, pc_in, pc_load_value;
  logic [2:0] reg_wr_sel;
  logic reg_wr_en, pc_load, ram_wr_en;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int m_acc = 0;
  int m_sw = 8;
  // Slots are only ever used as return stack, never as data
  logic [7:0] stk_lo [8] = '{default: 8'h00};
  logic [7:0] stk_hi [8] = '{default: 8'h00};

  cssb_core dut (.clk, .rst_b, .instr_valid, .instr, .bus_data, .branch_target, .pc_in,
    .irq_b, .user_flag_b, .timer_flag, .test_a, .test_b, .ram_rd_lo, .ram_rd_hi, .acc,
    .status_word, .reg_wr_data, .reg_wr_en, .reg_wr_sel, .pc_load, .pc_load_value,
    .ram_wr_en, .ram_addr, .ram_wr_lo, .ram_wr_hi);

  always #20 clk = ~clk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask

  task automatic chk_bit(input string w, input logic g, input logic e);
    chk(w, {11'h000, g}, {11'h000, e});
  endtask

  function automatic cssb_instr_type mk(cssb_op_type o, cssb_alu_type f = CSSB_ALU_PASS,
      cssb_branch_type c = CSSB_BR_NONE, logic d = 1'b0, logic r = 1'b0, logic s = 1'b0);
    mk = '{o, f, c, 3'($urandom_range(7)), d, r, s, 3'($urandom_range(7))};
  endfunction

  // Model first, then drive; expectations never look at the outputs
  task automatic run(input cssb_instr_type i, input logic [7:0] b);
    int r, cy, ac, ci, sp, pl, re, we, rd;
    logic [11:0] tg, pc, pv;
    tg = 12'($urandom);
    pc = 12'($urandom);
    sp = m_sw & 7;
    cy = (m_sw >> 7) & 1;
    ac = (m_sw >> 6) & 1;
    r = m_acc;
    pl = 0;
    re = 0;
    we = 0;
    rd = 0;
    pv = tg;
    ram_rd_lo = stk_lo[(sp - 1) & 7];
    ram_rd_hi = stk_hi[(sp - 1) & 7];
    case (i.op)
      CSSB_OP_ALU: begin
        case (i.alu_fn)
          CSSB_ALU_ADD, CSSB_ALU_ADDC: begin
            ci = (i.alu_fn == CSSB_ALU_ADDC) ? cy : 0;
            ac = ((m_acc & 8'h0f) + (b & 8'h0f) + ci) > 15;
            r = m_acc + b + ci;
            cy = r > 255;
          end
          CSSB_ALU_AND: r = m_acc & b;
          CSSB_ALU_OR: r = m_acc | b;
          CSSB_ALU_XOR: r = m_acc ^ b;
          CSSB_ALU_DA: begin
            if ((r & 8'h0f) > 9 || ac) r = r + 6;
            cy = cy | (r > 255);
            r = r & 8'hff;
            if ((r >> 4) > 9 || cy) r = r + 8'h60;
            cy = cy | (r > 255);
          end
          CSSB_ALU_INC: r = b + 1;
          CSSB_ALU_DEC: r = b - 1;
          CSSB_ALU_CPL: r = ~m_acc;
          CSSB_ALU_CLR: r = 0;
          CSSB_ALU_RL: r = (m_acc << 1) | (m_acc >> 7);
          CSSB_ALU_RLC: begin
            r = (m_acc << 1) | cy;
            cy = m_acc >> 7;
          end
          CSSB_ALU_RR: r = (m_acc >> 1) | (m_acc << 7);
          CSSB_ALU_RRC: begin
            r = (m_acc >> 1) | (cy << 7);
            cy = m_acc & 1;
          end
          CSSB_ALU_SWAP: r = (m_acc >> 4) | (m_acc << 4);
          default: r = b;
        endcase
        r = r & 8'hff;
        if (i.dst_reg) begin
          re = 1;
          rd = r;
        end else begin
          m_acc = r;
        end
        m_sw = (m_sw & 8'h3f) | (cy << 7) | (ac << 6);
      end
      CSSB_OP_BRANCH: begin
        case (i.br_cond)
          CSSB_BR_IRQ_LOW: pl = !irq_b;
          CSSB_BR_FLAG_A: pl = (m_sw >> 5) & 1;
          CSSB_BR_FLAG_B: pl = user_flag_b;
          CSSB_BR_TIMER: pl = timer_flag;
          CSSB_BR_CARRY: pl = cy;
          CSSB_BR_NO_CARRY: pl = !cy;
          CSSB_BR_ACC_ZERO: pl = m_acc == 0;
          CSSB_BR_ACC_NZ: pl = m_acc != 0;
          CSSB_BR_ACC_BIT: pl = (m_acc >> i.bit_sel) & 1;
          CSSB_BR_TA_HIGH: pl = test_a;
          CSSB_BR_TA_LOW: pl = !test_a;
          CSSB_BR_TB_HIGH: pl = test_b;
          CSSB_BR_TB_LOW: pl = !test_b;
          CSSB_BR_DEC_NZ: begin
            re = 1;
            rd = (b - 1) & 8'hff;
            pl = rd != 0;
          end
          default: pl = 0;
        endcase
      end
      CSSB_OP_CALL: begin
        we = 1;
        pl = 1;
        stk_lo[sp] = pc[7:0];
        stk_hi[sp] = {m_sw[7:4], pc[11:8]};
        m_sw = (m_sw & 8'hf8) | ((sp + 1) & 7);
      end
      CSSB_OP_RET: begin
        pl = 1;
        sp = (sp - 1) & 7;
        pv = {stk_hi[sp][3:0], stk_lo[sp]};
        if (i.ret_restore) m_sw = (m_sw & 8'h0f) | (stk_hi[sp] & 8'hf0);
        m_sw = (m_sw & 8'hf8) | sp;
      end
      CSSB_OP_SWMOVE: begin
        if (i.sw_to_acc) m_acc = m_sw;
        else m_sw = m_acc | 8'h08;
      end
      default: ;
    endcase
    instr = i;
    bus_data = b;
    branch_target = tg;
    pc_in = pc;
    instr_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("acc", {4'h0, acc}, 12'(m_acc));
    chk("status", {4'h0, status_word}, 12'(m_sw));
    chk_bit("pc_load", pc_load, pl[0]);
    chk_bit("reg_en", reg_wr_en, re[0]);
    chk_bit("ram_en", ram_wr_en, we[0]);
    if (pl != 0) chk("pc_value", pc_load_value, pv);
    if (re != 0) begin
      chk("reg_data", {1'b0, reg_wr_sel, reg_wr_data}, {1'b0, i.reg_sel, 8'(rd)});
    end
    if (we != 0) begin
      chk("ram_addr", {4'h0, ram_addr}, 12'(8 + 2 * sp));
      chk("ram_data", {ram_wr_hi, ram_wr_lo[3:0]}, {stk_hi[sp], stk_lo[sp][3:0]});
      chk("ram_lo", {4'h0, ram_wr_lo}, {4'h0, stk_lo[sp]});
    end
  endtask

  task automatic idle();
    instr_valid = 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("hold", {acc, status_word[3:0]}, {8'(m_acc), 4'(m_sw)});
    chk_bit("pulse", pc_load | reg_wr_en | ram_wr_en, 1'b0);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      $display("[ERR] %0t run too long", $time);
      conclude();
    end
  end

  initial begin
    int k;
    k = $urandom(45);
    rst_b = 1'b0;
    instr_valid = 1'b0;
    instr = mk(CSSB_OP_IDLE);
    {irq_b, user_flag_b, timer_flag, test_a, test_b} = 5'h10;
    {bus_data, ram_rd_lo, ram_rd_hi} = 24'h000000;
    {branch_target, pc_in} = 24'h000000;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("rst_acc", {4'h0, acc}, 12'h000);
    chk("rst_addr", {4'h0, ram_addr}, 12'h008);
    chk("rst_sw", {4'h0, status_word}, 12'h008);
    rst_b = 1'b1;
    $display("test reset done");
    for (k = 0; k < 300; k++) begin
      run(mk(CSSB_OP_ALU, cssb_alu_type'($urandom_range(14)), CSSB_BR_NONE,
        1'($urandom)), 8'($urandom));
    end
    idle();
    $display("test alu done");
    run(mk(CSSB_OP_ALU, CSSB_ALU_CLR), 8'h00);
    run(mk(CSSB_OP_ALU, CSSB_ALU_ADD), 8'h0f);
    run(mk(CSSB_OP_ALU, CSSB_ALU_ADD), 8'h01);
    run(mk(CSSB_OP_SWMOVE), 8'h00);
    for (k = 0; k < 20; k++) begin
      run(mk(CSSB_OP_ALU, CSSB_ALU_CLR), 8'h00);
      run(mk(CSSB_OP_ALU, CSSB_ALU_ADD), 8'($urandom));
      run(mk(CSSB_OP_SWMOVE), 8'h00);
      run(mk(CSSB_OP_ALU, CSSB_ALU_CLR), 8'h00);
      run(mk(CSSB_OP_SWMOVE, CSSB_ALU_PASS, CSSB_BR_NONE, 0, 0, 1), 8'h00);
    end
    idle();
    $display("test status done");
    for (k = 0; k < 140; k++) begin
      {irq_b, user_flag_b, timer_flag, test_a, test_b} = 5'($urandom);
      if (k % 3 == 0) run(mk(CSSB_OP_ALU, CSSB_ALU_CLR), 8'h00);
      else run(mk(CSSB_OP_ALU, CSSB_ALU_ADD), 8'($urandom));
      run(mk(CSSB_OP_BRANCH, CSSB_ALU_PASS, cssb_branch_type'(k % 14)),
        8'($urandom_range(2)));
    end
    idle();
    $display("test branch done");
    for (k = 0; k < 9; k++) begin
      run(mk(CSSB_OP_CALL), 8'h00);
      run(mk(CSSB_OP_ALU, CSSB_ALU_ADD), 8'($urandom));
    end
    for (k = 0; k < 10; k++) begin
      run(mk(CSSB_OP_RET, CSSB_ALU_PASS, CSSB_BR_NONE, 0, 1'(k)), 8'h00);
    end
    idle();
    $display("test stack done");
    conclude();
  end
endmodule

`default_nettype wire
